/* core_status_option_registers.v */
// Core flag register, option register, timer zero and prescaler behind an APB slave.
`timescale 1ns/1ps
`include "core_regs_consts.vh"

module core_status_option_registers #(
  parameter SYNC_STAGES = 3
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // Data-memory address formation from the core
  input wire [6:0] direct_addr,
  input wire [7:0] indirect_ptr,
  output reg [8:0] direct_mem_addr,
  output reg [8:0] indirect_mem_addr,
  // Watchdog side
  input wire watchdog_base_tick,
  input wire watchdog_timeout,
  output reg watchdog_tick,
  // Pins
  input wire ext_irq_pin,
  input wire timer_zero_clock_pin,
  input wire [7:0] port_latch,
  output reg [7:0] pullup_en,
  // Interrupt request toward the core
  output wire irq_request
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Terminal prescaler count for the rate field and assignment.
  function [7:0] rate_limit;
    input [2:0] rate;
    input to_watchdog;
    reg [8:0] ratio;
    begin
      ratio = (to_watchdog ? 9'h001 : 9'h002) << rate;
      rate_limit = ratio[7:0] - 8'h01;
    end
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] flags_ff;
  reg [7:0] option_ff;
  reg [7:0] result_ff;
  reg [7:0] timer_ff;
  reg [7:0] prescale_ff;
  reg [1:0] quarter_ff;
  reg [1:0] irq_flags_ff;
  reg [7:0] irq_en_ff;
  reg [2:0] ext_sync_ff;
  reg [2:0] tck_sync_ff;
  reg ext_level_ff;
  reg tck_level_ff;
  reg [7:0] nxt_flags;
  reg [7:0] nxt_result;
  reg [7:0] nxt_timer;
  reg [7:0] nxt_prescale;
  reg [1:0] nxt_irq_flags;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire access = psel & penable;
  wire wr_en = access & pwrite;
  wire hit_flags = (paddr == `OFS_FLAGS);
  wire hit_option = (paddr == `OFS_OPTION);
  wire hit_instr = (paddr == `OFS_INSTR);
  wire hit_result = (paddr == `OFS_RESULT);
  wire hit_timer = (paddr == `OFS_TIMER);
  wire hit_irq_flags = (paddr == `OFS_IRQ_FLAGS);
  wire hit_irq_en = (paddr == `OFS_IRQ_EN);
  wire mapped = hit_flags | hit_option | hit_instr | hit_result | hit_timer |
                hit_irq_flags | hit_irq_en;

  // The slave never stalls, so every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // ----------------------------------------
  // Instruction execution
  // ----------------------------------------
  wire exec = wr_en & hit_instr;
  wire [3:0] op = pwdata[`INS_OP_HI:`INS_OP_LO];
  wire dest_flags = pwdata[`INS_DEST_FLAGS];
  wire [7:0] opa = pwdata[`INS_A_HI:`INS_A_LO];
  wire [7:0] opb = pwdata[`INS_B_HI:`INS_B_LO];

  // Subtraction adds the two's complement, so carries read as no-borrow.
  wire is_sub = (op == `OP_SUB);
  wire [7:0] addend = is_sub ? ~opb : opb; // RQ12
  wire cin = is_sub; // RQ12
  wire [4:0] low_sum = {1'b0, opa[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  wire [8:0] full_sum = {1'b0, opa} + {1'b0, addend} + {8'h00, cin};
  reg [7:0] alu_out;
  reg z_upd;
  reg dc_upd;
  reg c_upd;
  reg c_val;
  reg writes_result;
  always @* begin
    alu_out = opa;
    z_upd = 1'b0;
    dc_upd = 1'b0;
    c_upd = 1'b0;
    c_val = flags_ff[`FLG_CARRY];
    writes_result = 1'b1;
    case (op)
      `OP_ADD, `OP_SUB: begin
        alu_out = full_sum[7:0];
        z_upd = 1'b1;
        dc_upd = 1'b1;
        c_upd = 1'b1;
        c_val = full_sum[8]; // RQ11
      end
      `OP_AND: begin
        alu_out = opa & opb;
        z_upd = 1'b1;
      end
      `OP_IOR: begin
        alu_out = opa | opb;
        z_upd = 1'b1;
      end
      `OP_XOR: begin
        alu_out = opa ^ opb;
        z_upd = 1'b1;
      end
      `OP_ROT_RIGHT: begin
        alu_out = {flags_ff[`FLG_CARRY], opa[7:1]};
        c_upd = 1'b1;
        c_val = opa[0]; // RQ13
      end
      `OP_ROT_LEFT: begin
        alu_out = {opa[6:0], flags_ff[`FLG_CARRY]};
        c_upd = 1'b1;
        c_val = opa[7]; // RQ13
      end
      `OP_CLEAR: begin
        alu_out = 8'h00;
        z_upd = 1'b1;
      end
      `OP_SWAP: alu_out = {opa[3:0], opa[7:4]};
      `OP_WDT_CLEAR, `OP_SLEEP: writes_result = 1'b0;
      default: alu_out = opa;
    endcase
  end

  // ----------------------------------------
  // Flag register next value
  // ----------------------------------------
  always @* begin
    nxt_flags = flags_ff;
    nxt_result = result_ff;
    if (wr_en && hit_flags) begin
      // A plain move writes every bit except the two reset-cause flags.
      nxt_flags = {pwdata[7:5], flags_ff[4:3], pwdata[2:0]}; // RQ2
    end
    if (exec) begin
      if (writes_result) begin
        nxt_result = alu_out;
      end
      if (writes_result && dest_flags) begin
        // Upper bits take the result and reset-cause flags never do; clear-file keeps carries.
        nxt_flags = {alu_out[7:5], flags_ff[4:3], alu_out[2],
                     (op == `OP_CLEAR) ? flags_ff[1:0] : alu_out[1:0]}; // RQ2 RQ3
      end
      // Hardware flag updates override the written value of the same bits.
      if (z_upd) begin
        nxt_flags[`FLG_ZERO] = (alu_out == 8'h00); // RQ1 RQ9 RQ3
      end
      if (dc_upd) begin
        nxt_flags[`FLG_DIGIT_CARRY] = low_sum[4]; // RQ1 RQ10
      end
      if (c_upd) begin
        nxt_flags[`FLG_CARRY] = c_val; // RQ1 RQ11 RQ13
      end
      if (op == `OP_WDT_CLEAR) begin
        nxt_flags[`FLG_TIMEOUT] = 1'b1; // RQ7
        nxt_flags[`FLG_POWER_DOWN] = 1'b1; // RQ8
      end
      if (op == `OP_SLEEP) begin
        nxt_flags[`FLG_TIMEOUT] = 1'b1; // RQ7
        nxt_flags[`FLG_POWER_DOWN] = 1'b0; // RQ8
      end
    end
    // A timeout event wins over a clear in the same cycle.
    if (watchdog_timeout) begin
      nxt_flags[`FLG_TIMEOUT] = 1'b0; // RQ7
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flags_ff <= `RST_FLAGS; // RQ7 RQ8
      result_ff <= 8'h00;
    end else begin
      flags_ff <= nxt_flags;
      result_ff <= nxt_result;
    end
  end

  // ----------------------------------------
  // Option and interrupt enable registers
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      option_ff <= `RST_OPTION;
      irq_en_ff <= 8'h00;
    end else begin
      if (wr_en && hit_option) begin
        option_ff <= pwdata[7:0];
      end
      if (wr_en && hit_irq_en) begin
        irq_en_ff <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Stage one feeds stage two only; a change counts once stages two and three agree.
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ext_sync_ff <= 3'b000;
      tck_sync_ff <= 3'b000;
      ext_level_ff <= 1'b0;
      tck_level_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[1:0], ext_irq_pin};
      tck_sync_ff <= {tck_sync_ff[1:0], timer_zero_clock_pin};
      if (ext_sync_ff[1] == ext_sync_ff[2]) begin
        ext_level_ff <= ext_sync_ff[2];
      end
      if (tck_sync_ff[1] == tck_sync_ff[2]) begin
        tck_level_ff <= tck_sync_ff[2];
      end
    end
  end
  wire ext_agree = (ext_sync_ff[1] == ext_sync_ff[2]);
  wire tck_agree = (tck_sync_ff[1] == tck_sync_ff[2]);
  wire ext_rise = ext_agree & ext_sync_ff[2] & ~ext_level_ff;
  wire ext_fall = ext_agree & ~ext_sync_ff[2] & ext_level_ff;
  wire tck_rise = tck_agree & tck_sync_ff[2] & ~tck_level_ff;
  wire tck_fall = tck_agree & ~tck_sync_ff[2] & tck_level_ff;
  wire ext_edge = option_ff[`OPT_IRQ_EDGE] ? ext_rise : ext_fall; // RQ15
  wire pin_tick = option_ff[`OPT_SRC_EDGE] ? tck_fall : tck_rise; // RQ17

  // ----------------------------------------
  // Timer zero source and shared prescaler
  // ----------------------------------------
  wire quarter_tick = (quarter_ff == `QUARTER_DIV - 1);
  wire timer_src = option_ff[`OPT_SRC_SEL] ? pin_tick : quarter_tick; // RQ16
  wire to_watchdog = option_ff[`OPT_ASSIGN];
  wire pre_in = to_watchdog ? watchdog_base_tick : timer_src; // RQ18
  wire [7:0] pre_limit = rate_limit(option_ff[`OPT_RATE_HI:`OPT_RATE_LO], to_watchdog); // RQ19
  wire pre_out = pre_in & (prescale_ff >= pre_limit);
  // Without the prescaler the timer sees its source one-to-one.
  wire timer_inc = to_watchdog ? timer_src : pre_out; // RQ20
  wire timer_wr = wr_en & hit_timer;
  always @* begin
    nxt_prescale = prescale_ff;
    if (pre_in) begin
      nxt_prescale = pre_out ? 8'h00 : prescale_ff + 8'h01;
    end
    // Writing the timer restarts the prescaler so the next count is whole.
    if (timer_wr) begin
      nxt_prescale = 8'h00;
    end
    nxt_timer = timer_ff;
    if (timer_wr) begin
      nxt_timer = pwdata[7:0];
    end else if (timer_inc) begin
      nxt_timer = timer_ff + 8'h01;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      quarter_ff <= 2'b00;
      prescale_ff <= 8'h00;
      timer_ff <= 8'h00;
      watchdog_tick <= 1'b0;
    end else begin
      quarter_ff <= quarter_tick ? 2'b00 : quarter_ff + 2'b01;
      prescale_ff <= nxt_prescale;
      timer_ff <= nxt_timer;
      watchdog_tick <= to_watchdog ? pre_out : watchdog_base_tick; // RQ18
    end
  end

  // ----------------------------------------
  // Interrupt flags
  // ----------------------------------------
  // Flags set from their events whatever the enables say; a set beats a write-one clear.
  wire timer_ovf = timer_inc & ~timer_wr & (timer_ff == 8'hFF);

  always @* begin
    nxt_irq_flags = irq_flags_ff;
    if (wr_en && hit_irq_flags) begin
      nxt_irq_flags = irq_flags_ff & ~pwdata[1:0];
    end
    if (timer_ovf) begin
      nxt_irq_flags[`IRQ_TIMER] = 1'b1; // RQ21
    end
    if (ext_edge) begin
      nxt_irq_flags[`IRQ_EXT] = 1'b1; // RQ21
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      irq_flags_ff <= 2'b00;
    end else begin
      irq_flags_ff <= nxt_irq_flags;
    end
  end

  // A stale flag requests at once when its enable is set, hence clear first.
  assign irq_request = irq_en_ff[`IRQ_GLOBAL] & |(irq_flags_ff & irq_en_ff[1:0]); // RQ22

  // ----------------------------------------
  // Address formation and pull-ups
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      direct_mem_addr <= 9'h000;
      indirect_mem_addr <= 9'h000;
      pullup_en <= 8'h00;
    end else begin
      direct_mem_addr <= {flags_ff[`FLG_BANK_HI:`FLG_BANK_LO], direct_addr}; // RQ6
      indirect_mem_addr <= {flags_ff[`FLG_INDIRECT_BANK], indirect_ptr}; // RQ5
      pullup_en <= option_ff[`OPT_PULLUP_DIS] ? 8'h00 : port_latch; // RQ14
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      case (paddr)
        `OFS_FLAGS: prdata[7:0] = flags_ff;
        `OFS_OPTION: prdata[7:0] = option_ff;
        `OFS_RESULT: prdata[7:0] = result_ff;
        `OFS_TIMER: prdata[7:0] = timer_ff;
        `OFS_IRQ_FLAGS: prdata[1:0] = irq_flags_ff;
        `OFS_IRQ_EN: prdata[7:0] = irq_en_ff;
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

endmodule

/* core_regs_consts.vh */
// Constants for the core flag and option register block.
//
// Behaviour
// RQ1: Result flags ignore writes when instruction updates them.
// RQ2: Timeout and power-down flags are read-only.
// RQ3: Clear-file on flags: bank zero, zero set.
// RQ4: Software alters flags only with non-flag instructions.
// RQ5: Indirect bank bit is upper indirect address bit.
// RQ6: Direct bank field selects bank zero to three.
// RQ7: Timeout set on power-up/clear/sleep, cleared on timeout.
// RQ8: Power-down set on power-up/clear, cleared on sleep.
// RQ9: Zero flag follows zero result.
// RQ10: Digit carry is carry out of bit three.
// RQ11: Carry is carry out of bit seven.
// RQ12: Subtract adds two's complement; carries mean no-borrow.
// RQ13: Rotates load carry with bit shifted out.
// RQ14: Pull-up disable bit gates all port-B pull-ups.
// RQ15: Edge-select bit picks rising or falling interrupt edge.
// RQ16: Source bit picks pin or quarter-clock for timer.
// RQ17: Source-edge bit picks timer pin edge.
// RQ18: Assignment bit gives prescaler to watchdog or timer.
// RQ19: Rate field: timer 1:2..1:256, watchdog 1:1..1:128.
// RQ20: Watchdog-assigned prescaler leaves timer undivided.
// RQ21: Interrupt flags set regardless of enables.
// RQ22: Software clears pending flag before enabling it.
`ifndef CORE_REGS_CONSTS_VH
`define CORE_REGS_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_FLAGS 12'h000
`define OFS_OPTION 12'h004
`define OFS_INSTR 12'h008
`define OFS_RESULT 12'h00C
`define OFS_TIMER 12'h010
`define OFS_IRQ_FLAGS 12'h014
`define OFS_IRQ_EN 12'h018

// ----------------------------------------
// Flag register fields
// ----------------------------------------
`define FLG_CARRY 0
`define FLG_DIGIT_CARRY 1
`define FLG_ZERO 2
`define FLG_POWER_DOWN 3
`define FLG_TIMEOUT 4
`define FLG_BANK_LO 5
`define FLG_BANK_HI 6
`define FLG_INDIRECT_BANK 7

// ----------------------------------------
// Option register fields
// ----------------------------------------
`define OPT_RATE_LO 0
`define OPT_RATE_HI 2
`define OPT_ASSIGN 3
`define OPT_SRC_EDGE 4
`define OPT_SRC_SEL 5
`define OPT_IRQ_EDGE 6
`define OPT_PULLUP_DIS 7

// ----------------------------------------
// Instruction register fields and opcodes
// ----------------------------------------
`define INS_OP_LO 0
`define INS_OP_HI 3
`define INS_DEST_FLAGS 4
`define INS_A_LO 8
`define INS_A_HI 15
`define INS_B_LO 16
`define INS_B_HI 23
`define OP_MOVE 4'h0
`define OP_ADD 4'h1
`define OP_SUB 4'h2
`define OP_AND 4'h3
`define OP_IOR 4'h4
`define OP_XOR 4'h5
`define OP_ROT_RIGHT 4'h6
`define OP_ROT_LEFT 4'h7
`define OP_CLEAR 4'h8
`define OP_WDT_CLEAR 4'h9
`define OP_SLEEP 4'hA
`define OP_SWAP 4'hB

// ----------------------------------------
// Interrupt bits
// ----------------------------------------
`define IRQ_TIMER 0
`define IRQ_EXT 1
`define IRQ_GLOBAL 7

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RST_FLAGS 8'h18
`define RST_OPTION 8'hFF
`define QUARTER_DIV 4

`endif

/* core_regs_checker_assertions.sv */
// Concurrent checks on the ports of the core flag and option register block.
`timescale 1ns/1ps
`include "core_regs_consts.vh"
module core_regs_checker (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pslverr,
  // Address formation
  input wire [6:0] direct_addr,
  input wire [7:0] indirect_ptr,
  input wire [8:0] direct_mem_addr,
  input wire [8:0] indirect_mem_addr,
  // Watchdog and pins
  input wire watchdog_base_tick,
  input wire watchdog_tick,
  input wire [7:0] port_latch,
  input wire [7:0] pullup_en
);
  // ----
  // Option shadow
  // ----
  // The shadow lets port checks see the option bits without reaching inside.
  reg [7:0] opt_ff;
  wire acc = psel && penable;
  wire mapped = (paddr <= `OFS_IRQ_EN) && (paddr[1:0] == 2'b00);
  wire [7:0] nxt_opt = (acc && pwrite && paddr == `OFS_OPTION) ? pwdata[7:0] : opt_ff;
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      opt_ff <= `RST_OPTION;
    end else begin
      opt_ff <= nxt_opt;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ----
  // Properties
  // ----
  property p_slverr;
    pslverr == (acc && !mapped);
  endproperty
  a_slverr: assert property (p_slverr) else $error("slave error wrong");
  property p_rd_idle;
    !(acc && !pwrite) |-> prdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
  property p_opt_read;
    acc && !pwrite && paddr == `OFS_OPTION |-> prdata == {24'h00_0000, opt_ff};
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("option readback wrong");
  property p_pullup;
    pullup_en == ($past(opt_ff[`OPT_PULLUP_DIS]) ? 8'h00 : $past(port_latch));
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up enables wrong");
  property p_direct;
    direct_mem_addr[6:0] == $past(direct_addr);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");
  property p_indirect;
    indirect_mem_addr[7:0] == $past(indirect_ptr);
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");
  property p_bank_hold;
    !$past(acc && pwrite, 2) |-> $stable(direct_mem_addr[8:7]) && $stable(indirect_mem_addr[8]);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("bank moved without write");
  property p_wdt_pass;
    !$past(opt_ff[`OPT_ASSIGN]) |-> watchdog_tick == $past(watchdog_base_tick);
  endproperty
  a_wdt_pass: assert property (p_wdt_pass) else $error("watchdog tick not passed");
  property p_wdt_src;
    watchdog_tick |-> $past(watchdog_base_tick);
  endproperty
  a_wdt_src: assert property (p_wdt_src) else $error("watchdog tick without base");
  c_instr: cover property (acc && pwrite && paddr == `OFS_INSTR);
  c_err: cover property (pslverr);
  c_wdt: cover property (watchdog_tick && opt_ff[`OPT_ASSIGN]);
endmodule

/* tb_core_status_option_registers.sv */
// Self-checking testbench for the core flag and option register block.
`timescale 1ns/1ps
`include "core_regs_consts.vh"
module tb_core_status_option_registers;
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [6:0] direct_addr = 7'h00;
  reg [7:0] indirect_ptr = 8'h00, port_latch = 8'h00, ef, er, v;
  reg wd_base = 1'b0, wd_to = 1'b0, ext_pin = 1'b0, t0_pin = 1'b0;
  wire pready, pslverr, watchdog_tick, irq_request;
  wire [31:0] prdata;
  wire [8:0] direct_mem_addr, indirect_mem_addr;
  wire [7:0] pullup_en;
  integer num_errors = 0, n_checks = 0, cycles = 0, wd_cnt = 0, i, k, e;
  reg [31:0] rnd = 32'h96e3_e5cf, rd;
  core_status_option_registers DUT (.clk_sys(clk_sys), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .direct_addr(direct_addr),
    .indirect_ptr(indirect_ptr), .direct_mem_addr(direct_mem_addr),
    .indirect_mem_addr(indirect_mem_addr), .watchdog_base_tick(wd_base),
    .watchdog_timeout(wd_to), .watchdog_tick(watchdog_tick), .ext_irq_pin(ext_pin),
    .timer_zero_clock_pin(t0_pin), .port_latch(port_latch), .pullup_en(pullup_en),
    .irq_request(irq_request));
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (watchdog_tick === 1'b1) wd_cnt <= wd_cnt + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      test_done;
    end
  end
  // ----
  // Helpers
  // ----
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [15:0] alu(input [3:0] op, input d, input [7:0] x, input [7:0] y, input [7:0] f);
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] r, n;
    begin
      s = {1'b0, x} + {1'b0, (op == `OP_SUB) ? ~y : y} + (op == `OP_SUB);
      h = {1'b0, x[3:0]} + {1'b0, (op == `OP_SUB) ? ~y[3:0] : y[3:0]} + (op == `OP_SUB);
      case (op)
        `OP_ADD, `OP_SUB: r = s[7:0];
        `OP_AND: r = x & y;
        `OP_IOR: r = x | y;
        `OP_XOR: r = x ^ y;
        `OP_ROT_RIGHT: r = {f[0], x[7:1]};
        `OP_ROT_LEFT: r = {x[6:0], f[0]};
        `OP_SWAP: r = {x[3:0], x[7:4]};
        `OP_CLEAR: r = 8'h00;
        default: r = x;
      endcase
      n = d ? {r[7:5], f[4:3], r[2:0]} : f;
      if (op == `OP_ADD || op == `OP_SUB) n[1:0] = {h[4], s[8]};
      if (op == `OP_ROT_RIGHT) n[0] = x[0];
      if (op == `OP_ROT_LEFT) n[0] = x[7];
      if (op >= `OP_ADD && op <= `OP_XOR) n[2] = (r == 8'h00);
      if (op == `OP_CLEAR) n = {d ? 3'b000 : f[7:5], f[4:3], 1'b1, f[1:0]};
      alu = {r, n};
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task apb(input wr, input [11:0] ad, input [31:0] wd);
    begin
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdr(input [11:0] ad);
    apb(1'b0, ad, 32'h0000_0000);
  endtask
  task exec(input [3:0] op, input d, input [7:0] x, input [7:0] y);
    begin
      apb(1'b1, `OFS_INSTR, {8'h00, y, x, 3'b000, d, op});
      if (op == `OP_WDT_CLEAR) ef[4:3] = 2'b11;
      else if (op == `OP_SLEEP) ef[4:3] = 2'b10;
      else {er, ef} = alu(op, d, x, y, ef);
      rdr(`OFS_RESULT);
      chk(rd, {24'h00_0000, er});
      rdr(`OFS_FLAGS);
      chk(rd, {24'h00_0000, ef});
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    ef = `RST_FLAGS;
    er = 8'h00;
    rdr(`OFS_FLAGS);
    chk(rd, `RST_FLAGS);
    rdr(12'h01c);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, `OFS_RESULT, 32'h0000_00a5);
    rdr(`OFS_RESULT);
    chk(rd, 32'h0000_0000);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = nx(rnd);
      v = {rnd[7], i[1:0], rnd[4:0]};
      direct_addr <= rnd[14:8];
      indirect_ptr <= rnd[23:16];
      apb(1'b1, `OFS_FLAGS, {24'h00_0000, v});
      ef = {v[7:5], ef[4:3], v[2:0]};
      rdr(`OFS_FLAGS);
      chk(rd, {24'h00_0000, ef});
      chk(direct_mem_addr, {i[1:0], rnd[14:8]});
      chk(indirect_mem_addr, {rnd[7], rnd[23:16]});
    end
    exec(`OP_ADD, 1'b0, 8'h0f, 8'h01);
    exec(`OP_SUB, 1'b0, 8'h05, 8'h05);
    exec(`OP_SUB, 1'b0, 8'h03, 8'h05);
    exec(`OP_AND, 1'b0, 8'hf0, 8'h0f);
    exec(`OP_ROT_RIGHT, 1'b0, 8'h81, 8'h00);
    exec(`OP_ROT_LEFT, 1'b0, 8'h81, 8'h00);
    exec(`OP_ADD, 1'b0, 8'hff, 8'h01);
    exec(`OP_CLEAR, 1'b1, 8'h00, 8'h00);
    exec(`OP_ADD, 1'b1, 8'he0, 8'h40);
    exec(`OP_MOVE, 1'b1, 8'ha5, 8'h00);
    exec(`OP_SWAP, 1'b1, 8'h5a, 8'h00);
    for (i = 0; i < 40; i = i + 1) begin
      rnd = nx(rnd);
      exec({1'b0, rnd[2:0]}, rnd[3] & ~rnd[2] & ~rnd[1], rnd[15:8], rnd[23:16]);
    end
    exec(`OP_SLEEP, 1'b0, 8'h00, 8'h00);
    @(posedge clk_sys);
    wd_to <= 1'b1;
    @(posedge clk_sys);
    wd_to <= 1'b0;
    ef[4] = 1'b0;
    rdr(`OFS_FLAGS);
    chk(rd, {24'h00_0000, ef});
    exec(`OP_WDT_CLEAR, 1'b0, 8'h00, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = nx(rnd);
      v = {rnd[7:3], i[2:0]};
      port_latch <= rnd[15:8];
      apb(1'b1, `OFS_OPTION, {24'h00_0000, v});
      rdr(`OFS_OPTION);
      chk(rd, {24'h00_0000, v});
      chk(pullup_en, v[7] ? 8'h00 : rnd[15:8]);
    end
    for (i = 0; i < 5; i = i + 1) begin
      apb(1'b1, `OFS_OPTION, (i < 4) ? 32'h0000_0088 + i : 32'h0000_0087);
      apb(1'b1, `OFS_TIMER, 32'h0000_0000);
      k = wd_cnt;
      repeat ((i < 4) ? (4 << i) : 4) begin
        @(posedge clk_sys);
        wd_base <= 1'b1;
        @(posedge clk_sys);
        wd_base <= 1'b0;
      end
      repeat (3) @(posedge clk_sys);
      chk(wd_cnt - k, 4);
    end
    for (i = 0; i < 9; i = i + 1) begin
      apb(1'b1, `OFS_OPTION, (i < 8) ? 32'h0000_0080 + i : 32'h0000_0088);
      apb(1'b1, `OFS_TIMER, 32'h0000_0000);
      repeat (12 * ((i < 8) ? (2 << i) : 1)) @(posedge clk_sys);
      rdr(`OFS_TIMER);
      chk(rd >= 3 && rd <= 4, 1);
    end
    for (e = 0; e < 2; e = e + 1) begin
      apb(1'b1, `OFS_OPTION, 32'h0000_00a8 + 16 * e);
      apb(1'b1, `OFS_TIMER, 32'h0000_0000);
      repeat (9) begin
        t0_pin <= ~t0_pin;
        repeat (8) @(posedge clk_sys);
      end
      rdr(`OFS_TIMER);
      chk(rd, 5 - e);
      t0_pin <= 1'b0;
      ext_pin <= e[0];
      apb(1'b1, `OFS_OPTION, {24'h00_0000, 1'b1, e[0], 6'h08});
      apb(1'b1, `OFS_IRQ_FLAGS, 32'h0000_0003);
      ext_pin <= ~e[0];
      repeat (8) @(posedge clk_sys);
      rdr(`OFS_IRQ_FLAGS);
      chk(rd[1], 0);
      ext_pin <= e[0];
      repeat (8) @(posedge clk_sys);
      rdr(`OFS_IRQ_FLAGS);
      chk(rd[1], 1);
      chk(irq_request, 0);
      apb(1'b1, `OFS_IRQ_EN, 32'h0000_0082);
      @(negedge clk_sys);
      chk(irq_request, 1);
      apb(1'b1, `OFS_IRQ_FLAGS, 32'h0000_0002);
      @(negedge clk_sys);
      chk(irq_request, 0);
      apb(1'b1, `OFS_IRQ_EN, 32'h0000_0000);
    end
    test_done;
  end
endmodule
bind core_status_option_registers core_regs_checker u_chk (.clk_sys(clk_sys),
  .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .direct_addr(direct_addr),
  .indirect_ptr(indirect_ptr), .direct_mem_addr(direct_mem_addr),
  .indirect_mem_addr(indirect_mem_addr), .watchdog_base_tick(watchdog_base_tick),
  .watchdog_tick(watchdog_tick), .port_latch(port_latch), .pullup_en(pullup_en));
